// ---- hw/pdr_ports.sv ----
// Direction and data registers for all general-purpose ports except the output-only port, which has a data register only.
// Assumes the CPU bus is synchronous to mclk and pins are
// already synchronised to mclk.
`timescale 1ns/1ns
`default_nettype none

module pdr_ports
    import pdr_pkg::*;
#(
    parameter int PORT_COUNT = PDR_PORT_COUNT
)
(
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // CPU internal bus
    input wire pdr_bus_req_t busReq,
    output logic [7:0] busRdData,
    output logic busRdValid,
    // External clock mode of clock-capable pins
    input wire logic [PDR_CLK_BITS-1:0] extClkMode,
    // Pins
    input wire logic [PORT_COUNT-1:0][7:0] pinIn,
    output logic [PORT_COUNT-1:0][7:0] pinOut,
    output logic [PORT_COUNT-1:0][7:0] pinOe
);

    pdr_state_t stateReg;
    pdr_state_t stateNext;

    logic [PORT_COUNT-1:0] dataSel;
    logic [PORT_COUNT-1:0] dirSel;
    logic [PORT_COUNT-1:0][7:0] readValue;
    logic [PORT_COUNT-1:0][7:0] clkForce;
    logic [7:0] clkMask;
    logic [7:0] rdValue;
    logic anyWrite;

    generate
        if (PORT_COUNT != PDR_PORT_COUNT)
        begin : g_bad_count
            $error("PORT_COUNT must match the port map");
        end
    endgenerate

    function automatic pdr_byte_t pdr_merge(
        input pdr_byte_t old,
        input pdr_bus_req_t req
    );
        pdr_byte_t r;
        r = old;
        if (req.wrByte)
        begin
            r = req.wrData;
        end
        else
        begin
            r[req.bitSel] = req.wrData[req.bitSel];
        end
        return r;
    endfunction

    assign clkMask = 8'({4'h0, extClkMode} << PDR_CLK_LSB);
    assign anyWrite = busReq.wrByte | busReq.wrBit;

    generate
        for (genvar g = 0; g < PORT_COUNT; g++)
        begin : g_port
            assign dataSel[g] = busReq.addr == PDR_DATA_OFS[g];
            // One direction register per port, except the output-only port whose PDR_HAS_DIR bit is 0
            assign dirSel[g] = PDR_HAS_DIR[g]
                && busReq.addr == PDR_DIR_OFS[g];
            assign clkForce[g] = (g == PDR_CLK_PORT) ? clkMask : 8'h00;

            pdr_port_slice u_slice (
                .latch(stateReg.latch[g]),
                .dir(stateReg.dir[g]),
                .implMask(PDR_IMPL_MASK[g]),
                .forceOut(PDR_FORCE_OUT[g]),
                .openDrain(PDR_OPEN_DRAIN[g]),
                .clkForce(clkForce[g]),
                .pinIn(pinIn[g]),
                .pinOut(pinOut[g]),
                .pinOe(pinOe[g]),
                .readValue(readValue[g])
            );
        end
    endgenerate

    always_comb
    begin
        stateNext = stateReg;
        stateNext.rdValid = 1'b0;
        rdValue = 8'h00;
        for (int p = 0; p < PORT_COUNT; p++)
        begin
            if (anyWrite && dataSel[p])
            begin
                // Latch loads whatever the direction
                stateNext.latch[p] = pdr_merge(stateReg.latch[p], busReq)
                    & PDR_IMPL_MASK[p];
            end
            if (anyWrite && dirSel[p])
            begin
                stateNext.dir[p] = pdr_merge(stateReg.dir[p], busReq)
                    | ~PDR_IMPL_MASK[p];
            end
            if (dataSel[p])
            begin
                rdValue = readValue[p];
            end
            if (dirSel[p])
            begin
                rdValue = stateReg.dir[p];
            end
        end
        if (busReq.rd)
        begin
            stateNext.rdData = rdValue;
            stateNext.rdValid = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            stateReg <= PDR_STATE_RESET;
        end
        else if (ce)
        begin
            stateReg <= stateNext;
        end
    end

    assign busRdData = stateReg.rdData;
    assign busRdValid = stateReg.rdValid;

    // Helpers for the checks below
    logic [7:0] selMask;
    logic port1DataRd;
    logic port1DataWr;
    logic port1DirWr;
    logic port1DirBitWr;
    logic port12DataRd;
    logic port0DirRd;
    logic port0DataRd;

    assign selMask = 8'(8'h01 << busReq.bitSel);
    assign port1DataRd = ce && busReq.rd
        && busReq.addr == PDR_DATA_OFS[PDR_IX_PORT1];
    assign port1DataWr = ce && busReq.addr == PDR_DATA_OFS[PDR_IX_PORT1];
    assign port1DirWr = ce && busReq.wrByte
        && busReq.addr == PDR_DIR_OFS[PDR_IX_PORT1];
    assign port1DirBitWr = ce && busReq.wrBit && !busReq.wrByte
        && busReq.addr == PDR_DIR_OFS[PDR_IX_PORT1];
    assign port12DataRd = ce && busReq.rd
        && busReq.addr == PDR_DATA_OFS[PDR_IX_PORT12];
    assign port0DirRd = ce && busReq.rd
        && busReq.addr == PDR_DIR_OFS[PDR_IX_PORT0];
    assign port0DataRd = ce && busReq.rd
        && busReq.addr == PDR_DATA_OFS[PDR_IX_PORT0];

    // Reset and storage
    chk_reset_values: assert property (
        @(posedge mclk) disable iff (rst)
        $fell(rst) |-> (stateReg.dir == {PORT_COUNT{8'hFF}})
    ) else $error("direction not all ones after reset");

    chk_reset_latch: assert property (
        @(posedge mclk) disable iff (rst)
        $fell(rst) |-> (stateReg.latch == '0) && (pinOut == '0)
    ) else $error("output latch not cleared after reset");

    chk_byte_write: assert property (
        @(posedge mclk) disable iff (rst)
        port1DataWr && busReq.wrByte
        |=> stateReg.latch[PDR_IX_PORT1] == $past(busReq.wrData)
    ) else $error("byte write not loaded into latch");

    chk_bit_write: assert property (
        @(posedge mclk) disable iff (rst)
        port1DataWr && busReq.wrBit && !busReq.wrByte
        |=> ((stateReg.latch[PDR_IX_PORT1]
            ^ $past(stateReg.latch[PDR_IX_PORT1])) & ~$past(selMask)) == 8'h00
            && (stateReg.latch[PDR_IX_PORT1] & $past(selMask))
            == ($past(busReq.wrData) & $past(selMask))
    ) else $error("bit write did not load only the chosen bit");

    chk_dir_bit_write: assert property (
        @(posedge mclk) disable iff (rst)
        port1DirBitWr
        |=> ((stateReg.dir[PDR_IX_PORT1]
            ^ $past(stateReg.dir[PDR_IX_PORT1])) & ~$past(selMask)) == 8'h00
            && (stateReg.dir[PDR_IX_PORT1] & $past(selMask))
            == ($past(busReq.wrData) & $past(selMask))
    ) else $error("direction bit write disturbed other bits");

    chk_unimpl_store: assert property (
        @(posedge mclk) disable iff (rst)
        stateReg.latch[PDR_IX_PORT0][7:2] == 6'h00
            && stateReg.dir[PDR_IX_PORT0][7:2] == 6'h3F
    ) else $error("unimplemented bits stored a write");

    chk_ce_freeze: assert property (
        @(posedge mclk) disable iff (rst)
        !ce |=> stateReg == $past(stateReg)
    ) else $error("state changed while clock enable low");

    // Pin drive
    chk_pin_drive: assert property (
        @(posedge mclk) disable iff (rst)
        pinOut[PDR_IX_PORT1] == stateReg.latch[PDR_IX_PORT1]
    ) else $error("pin level differs from latch");

    chk_dir_drive: assert property (
        @(posedge mclk) disable iff (rst)
        pinOe[PDR_IX_PORT1] == ~stateReg.dir[PDR_IX_PORT1]
    ) else $error("buffer enable not the inverse of direction");

    chk_oe_timing: assert property (
        @(posedge mclk) disable iff (rst)
        port1DirWr |-> pinOe[PDR_IX_PORT1] == ~stateReg.dir[PDR_IX_PORT1]
            ##1 pinOe[PDR_IX_PORT1] == ~$past(busReq.wrData)
    ) else $error("buffer enable not one cycle after write");

    chk_input_write: assert property (
        @(posedge mclk) disable iff (rst)
        port1DataWr && busReq.wrByte && stateReg.dir[PDR_IX_PORT1] == 8'hFF
        |=> pinOe[PDR_IX_PORT1] == 8'h00
    ) else $error("input-mode write turned on the buffer");

    chk_clk_no_drive: assert property (
        @(posedge mclk) disable iff (rst)
        (pinOe[PDR_IX_PORT12][4:1] & extClkMode) == 4'h0
    ) else $error("clock-mode pin still driven");

    // Read-back
    chk_read_pulse: assert property (
        @(posedge mclk) disable iff (rst)
        ce |=> busRdValid == $past(busReq.rd)
    ) else $error("read valid not one cycle after request");

    chk_read_input: assert property (
        @(posedge mclk) disable iff (rst)
        port1DataRd && stateReg.dir[PDR_IX_PORT1] == 8'hFF
        |=> busRdValid && busRdData == $past(pinIn[PDR_IX_PORT1])
    ) else $error("input read did not return pin level");

    chk_read_output: assert property (
        @(posedge mclk) disable iff (rst)
        port1DataRd && stateReg.dir[PDR_IX_PORT1] == 8'h00
        |=> busRdValid && busRdData == $past(stateReg.latch[PDR_IX_PORT1])
    ) else $error("output read did not return latch");

    chk_clk_read: assert property (
        @(posedge mclk) disable iff (rst)
        port12DataRd && extClkMode == 4'hF |=> busRdData[4:1] == 4'h0
    ) else $error("clock-mode bits did not read zero");

    chk_unimpl_dir: assert property (
        @(posedge mclk) disable iff (rst)
        port0DirRd |=> busRdData[7:2] == 6'h3F
    ) else $error("unimplemented direction bits not one");

    chk_unimpl_data: assert property (
        @(posedge mclk) disable iff (rst)
        port0DataRd |=> busRdData[7:2] == 6'h00
    ) else $error("unimplemented data bits not zero");

    chk_unmapped_read: assert property (
        @(posedge mclk) disable iff (rst)
        ce && busReq.rd && !(|dataSel) && !(|dirSel)
        |=> busRdData == 8'h00
    ) else $error("unmapped read returned data");

    // Scenario coverage
    cov_bit_write: cover property (
        @(posedge mclk) disable iff (rst)
        port1DataWr && busReq.wrBit && !busReq.wrByte
    );

    cov_dir_output: cover property (
        @(posedge mclk) disable iff (rst)
        port1DirWr && busReq.wrData == 8'h00 ##1 port1DataWr ##1 port1DataRd
    );

    cov_input_read: cover property (
        @(posedge mclk) disable iff (rst)
        port1DataRd && stateReg.dir[PDR_IX_PORT1] == 8'hFF
    );

    cov_clk_read: cover property (
        @(posedge mclk) disable iff (rst)
        port12DataRd && extClkMode != 4'h0
    );

    cov_ce_freeze: cover property (
        @(posedge mclk) disable iff (rst)
        !ce && busReq.rd ##1 ce
    );

endmodule // pdr_ports

`default_nettype wire

// ---- hw/pdr_pkg.sv ----
// Constants, types and register map of the port direction/data block.
// Assumes one CPU clock and a single 8-bit internal bus master.

package pdr_pkg;

    localparam int PDR_PORT_COUNT = 10;
    localparam int PDR_ADDR_W = 16;

    typedef logic [7:0] pdr_byte_t;

    // Port index order: 0,1,2,3,4,6,7,12,13,14
    localparam int PDR_IX_PORT0 = 0;
    localparam int PDR_IX_PORT1 = 1;
    localparam int PDR_IX_PORT12 = 7;

    localparam logic [15:0] PDR_DATA_OFS [PDR_PORT_COUNT] = '{
        16'hFF00, 16'hFF01, 16'hFF02, 16'hFF03, 16'hFF04,
        16'hFF06, 16'hFF07, 16'hFF0C, 16'hFF0D, 16'hFF0E};
    localparam logic [15:0] PDR_DIR_OFS [PDR_PORT_COUNT] = '{
        16'hFF20, 16'hFF21, 16'hFF22, 16'hFF23, 16'hFF24,
        16'hFF26, 16'hFF27, 16'hFF2C, 16'h0000, 16'hFF2E};
    // Output-only port has no direction register
    localparam logic [PDR_PORT_COUNT-1:0] PDR_HAS_DIR = 10'h2FF;

    localparam pdr_byte_t PDR_IMPL_MASK [PDR_PORT_COUNT] = '{
        8'h03, 8'hFF, 8'hFF, 8'h0F, 8'h03,
        8'h0F, 8'h3F, 8'h1F, 8'h01, 8'h01};
    localparam pdr_byte_t PDR_FORCE_OUT [PDR_PORT_COUNT] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    localparam pdr_byte_t PDR_OPEN_DRAIN [PDR_PORT_COUNT] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h0F, 8'h00, 8'h00, 8'h00, 8'h00};

    localparam pdr_byte_t PDR_LATCH_RESET = 8'h00;
    localparam pdr_byte_t PDR_DIR_RESET = 8'hFF;
    localparam pdr_byte_t PDR_RD_RESET = 8'h00;

    // Clock-capable pins sit in port 12 bits 1 to 4
    localparam int PDR_CLK_PORT = PDR_IX_PORT12;
    localparam int PDR_CLK_LSB = 1;
    localparam int PDR_CLK_BITS = 4;

    typedef struct packed {
        logic [PDR_ADDR_W-1:0] addr;
        logic wrByte;
        logic wrBit;
        logic [2:0] bitSel;
        pdr_byte_t wrData;
        logic rd;
    } pdr_bus_req_t;

    typedef struct packed {
        logic [PDR_PORT_COUNT-1:0][7:0] latch;
        logic [PDR_PORT_COUNT-1:0][7:0] dir;
        pdr_byte_t rdData;
        logic rdValid;
    } pdr_state_t;

    localparam pdr_state_t PDR_STATE_RESET = '{
        latch: {PDR_PORT_COUNT{PDR_LATCH_RESET}},
        dir: {PDR_PORT_COUNT{PDR_DIR_RESET}},
        rdData: PDR_RD_RESET,
        rdValid: 1'b0};

endpackage

// ---- hw/pdr_port_slice.sv ----
// One port's pin drive and read-back selection.
// Assumes registered latch and direction values from the parent.
`timescale 1ns/1ns
`default_nettype none

module pdr_port_slice
    import pdr_pkg::*;
(
    // Stored state
    input wire logic [7:0] latch,
    input wire logic [7:0] dir,
    // Port shape
    input wire logic [7:0] implMask,
    input wire logic [7:0] forceOut,
    input wire logic [7:0] openDrain,
    input wire logic [7:0] clkForce,
    // Pins
    input wire logic [7:0] pinIn,
    output logic [7:0] pinOut,
    output logic [7:0] pinOe,
    // Read-back
    output logic [7:0] readValue
);

    logic [7:0] effDir;

    always_comb
    begin
        effDir = dir & ~forceOut;
        // Input bits give pin level, output bits give latch
        readValue = ((effDir & pinIn) | (~effDir & latch));
        readValue = readValue & implMask & ~clkForce;
        // Buffer on only while effective direction bit is 0 (forceOut bits count as 0)
        pinOe = ~effDir & implMask & ~clkForce;
        // Open-drain bits only pull low
        pinOe = pinOe & ~(openDrain & latch);
        pinOut = latch & implMask & ~openDrain;
    end

endmodule // pdr_port_slice

`default_nettype wire

// ---- verification/test_port_direction_and_data_regs.sv ----
// Self-checking bench for the port direction and data registers.
// Assumes pdr_pkg and pdr_ports are compiled before this file.
`timescale 1ns/1ns
`default_nettype none

module test_port_direction_and_data_regs;
    import pdr_pkg::*;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    pdr_bus_req_t busReq = '0;
    logic [7:0] busRdData;
    logic busRdValid;
    logic [PDR_CLK_BITS-1:0] extClkMode = '0;
    logic [PDR_PORT_COUNT-1:0][7:0] pinIn = '0;
    logic [PDR_PORT_COUNT-1:0][7:0] pinOut;
    logic [PDR_PORT_COUNT-1:0][7:0] pinOe;
    pdr_byte_t latchM [PDR_PORT_COUNT];
    pdr_byte_t dirM [PDR_PORT_COUNT];
    pdr_byte_t expQ [$];
    int miscompares = 0;
    int compares = 0;
    logic [31:0] seed = 32'h2B69B7A9;
    logic [31:0] r;

    always #5 mclk = ~mclk;

    pdr_ports #(.PORT_COUNT(PDR_PORT_COUNT)) dut (
        .mclk(mclk), .rst(rst), .ce(ce), .busReq(busReq),
        .busRdData(busRdData), .busRdValid(busRdValid),
        .extClkMode(extClkMode), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Clock-mode pins of port 12 read zero and never drive
    function automatic pdr_byte_t clkBits(int i);
        return (i == PDR_CLK_PORT) ? 8'(extClkMode) << PDR_CLK_LSB : 8'h00;
    endfunction

    function automatic pdr_byte_t readExp(int i, bit isDir);
        pdr_byte_t d;
        pdr_byte_t v;
        d = dirM[i] & ~PDR_FORCE_OUT[i];
        v = ((d & pinIn[i]) | (~d & latchM[i])) & PDR_IMPL_MASK[i];
        return isDir ? dirM[i] : (v & ~clkBits(i));
    endfunction

    function automatic pdr_byte_t oeExp(int i);
        pdr_byte_t d;
        d = dirM[i] & ~PDR_FORCE_OUT[i];
        return ~d & PDR_IMPL_MASK[i] & ~(PDR_OPEN_DRAIN[i] & latchM[i])
            & ~clkBits(i);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Kinds: 0/1 byte write data/dir, 2/3 bit write, 4/5 read,
    // 6 unmapped read, 7 unmapped write, 8 idle
    // Software write rules on unbonded and unimplemented bits
    function automatic pdr_byte_t swShape(int kind, int i, pdr_byte_t w);
        pdr_byte_t v;
        v = w;
        if (kind inside {1, 3} && PDR_HAS_DIR[i])
        begin
            v = v | ~PDR_IMPL_MASK[i];
            v = v & ((i == 4) ? 8'hFC : (i == 6) ? 8'hF3 : 8'hFF);
        end
        else
        begin
            v = v & PDR_IMPL_MASK[i];
            v = v & ((i == 2) ? 8'h3F : (i == 4) ? 8'hFC
                : (i == 6) ? 8'hF3 : 8'hFF);
        end
        return v;
    endfunction

    task automatic issue(int kind, int i, logic [2:0] b, pdr_byte_t w);
        pdr_byte_t old;
        pdr_bus_req_t q;
        if (kind inside {1, 3, 5} && !PDR_HAS_DIR[i])
            kind = kind - 1;
        q = '0;
        q.bitSel = b;
        q.wrData = w;
        q.addr = kind inside {1, 3, 5} ? PDR_DIR_OFS[i] : PDR_DATA_OFS[i];
        if (kind >= 6)
            q.addr = 16'hFF10;
        q.wrByte = kind inside {0, 1, 7};
        q.wrBit = kind inside {2, 3};
        q.rd = kind inside {4, 5, 6};
        // One assignment per step keeps strobes glitch-free
        busReq = q;
        if (ce)
        begin
            if (q.rd)
                expQ.push_back(kind == 6 ? 8'h00 : readExp(i, kind == 5));
            old = kind inside {1, 3} ? dirM[i] : latchM[i];
            old[b] = w[b];
            if (kind inside {2, 3})
                w = old;
            if (kind inside {0, 2})
                latchM[i] = w & PDR_IMPL_MASK[i];
            if (kind inside {1, 3})
                dirM[i] = w | ~PDR_IMPL_MASK[i];
        end
    endtask

    task automatic step(int kind, int i, logic [2:0] b, pdr_byte_t w,
        bit rnd);
        logic [31:0] q;
        @(negedge mclk);
        for (int p = 0; p < PDR_PORT_COUNT; p++)
        begin
            check(pinOe[p], oeExp(p));
            check(pinOut[p], latchM[p] & ~PDR_OPEN_DRAIN[p]);
        end
        if (rnd)
        begin
            q = xs();
            ce = (q[2:0] != 3'h0);
            extClkMode = q[3] ? q[7:4] : 4'h0;
            for (int p = 0; p < PDR_PORT_COUNT; p++)
                pinIn[p] = pdr_byte_t'(xs());
        end
        issue(kind, i, b, w);
    endtask

    task automatic do_reset();
        @(negedge mclk);
        rst = 1'b1;
        busReq = '0;
        repeat (3) @(negedge mclk);
        expQ.delete();
        for (int p = 0; p < PDR_PORT_COUNT; p++)
        begin
            latchM[p] = 8'h00;
            dirM[p] = 8'hFF;
        end
        rst = 1'b0;
    endtask

    task automatic print_verdict();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Read results, oldest note first
    always @(posedge mclk)
        if (busRdValid === 1'b1 && ce === 1'b1)
        begin
            if (expQ.size() == 0)
                check({7'h00, busRdValid}, 8'h00);
            else
                check(busRdData, expQ.pop_front());
        end

    initial
    begin
        #50000;
        miscompares++;
        print_verdict();
    end

    initial
    begin
        do_reset();
        pinIn = '1;
        for (int p = 0; p < PDR_PORT_COUNT; p++)
        begin
            step(5, p, 3'h0, 8'h00, 1'b0);
            step(4, p, 3'h0, 8'h00, 1'b0);
            step(1, p, 3'h0, 8'h00, 1'b0);
            step(4, p, 3'h0, 8'h00, 1'b0);
        end
        for (int n = 0; n < 800; n++)
        begin
            if (n == 400)
                do_reset();
            r = xs();
            // Second half writes as package-aware software would
            step(r[2:0], (r >> 3) % 10, r[10:8], (n < 400) ? r[23:16]
                : swShape(r[2:0], (r >> 3) % 10, r[23:16]), 1'b1);
        end
        // Drop the last request so a late enable adds no write
        @(negedge mclk);
        busReq = '0;
        ce = 1'b1;
        repeat (3) step(8, 0, 3'h0, 8'h00, 1'b0);
        check(8'(expQ.size()), 8'h00);
        print_verdict();
    end

endmodule // test_port_direction_and_data_regs

`default_nettype wire
